// >>> design/skip_exec_pkg.sv
package skip_exec_pkg;
   // ----------------------------------------
   // widths
   // ----------------------------------------
   localparam int DATA_W = 8;
   localparam int PAGE_W = 5;
   localparam int PADDR_W = 13;
   localparam int BUS_AW = 11;

   // ----------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [10:0] OFS_INSTR = 11'h000;
   localparam logic [10:0] OFS_ACC = 11'h004;
   localparam logic [10:0] OFS_STATUS = 11'h008;
   localparam logic [10:0] OFS_TABLE_POINTER = 11'h00C;
   localparam logic [10:0] OFS_PC_PAGE = 11'h010;
   localparam logic [10:0] OFS_TABLE_HIGH = 11'h014;
   localparam logic [10:0] OFS_CYCLES = 11'h018;
   localparam int DMEM_SEL_BIT = 10;

   // ----------------------------------------
   // instruction word fields
   // ----------------------------------------
   localparam int OP_LSB = 0;
   localparam int BIT_LSB = 4;
   localparam int MADDR_LSB = 8;
   localparam int IMM_LSB = 16;

   // ----------------------------------------
   // status bits
   // ----------------------------------------
   localparam int FLAG_C = 0;
   localparam int FLAG_AC = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_OV = 3;
   localparam int STAT_SKIP = 4;

   // ----------------------------------------
   // reset values and constants
   // ----------------------------------------
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [3:0] FLAGS_RST = 4'h0;
   localparam logic [7:0] TABLE_POINTER_RST = 8'h00;
   localparam logic [4:0] PAGE_RST = 5'h00;
   localparam logic [7:0] TABLE_HIGH_BYTE_LATCH_RST = 8'h00;
   localparam logic [4:0] LAST_PAGE = 5'h1F;
   localparam logic [7:0] FILL_BYTE = 8'hFF;

   // ----------------------------------------
   // timing, in instruction cycles
   // ----------------------------------------
   localparam logic [1:0] CYC_NOSKIP = 2'h1;
   localparam logic [1:0] CYC_SKIP = 2'h2;
   localparam logic [1:0] CYC_TABLE = 2'h2;

   typedef enum logic [3:0] {
      op_dec_to_acc_skip_zero,
      op_set_byte,
      op_set_bit,
      op_inc_skip_zero,
      op_inc_to_acc_skip_zero,
      op_skip_bit_nonzero,
      op_subtract_to_acc,
      op_subtract_to_memory,
      op_subtract_immediate,
      op_nibble_exchange,
      op_nibble_exchange_to_acc,
      op_skip_if_zero,
      op_copy_skip_if_zero,
      op_skip_bit_zero,
      op_table_read_current_page,
      op_table_read_last_page
   } op_t;
endpackage

// >>> design/skip_exec_alu.sv
`timescale 1ns/1ps
module skip_exec_alu (
   input wire skip_exec_pkg::op_t i_op,
   input wire logic [7:0] i_acc,
   input wire logic [7:0] i_mem,
   input wire logic [7:0] i_imm,
   input wire logic [2:0] i_bit,
   input wire logic [3:0] i_flags,
   output logic [7:0] o_result,
   output logic o_wr_mem,
   output logic o_wr_acc,
   output logic o_skip,
   output logic [3:0] o_flags,
   output logic o_table
);
   // ----------------------------------------
   // subtract as a + ~b + 1, flags packed {ov,z,ac,c}
   // ----------------------------------------
   function automatic logic [11:0] subtract(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] full;
      logic [4:0] low;
      logic [7:0] nb;
      nb = ~b;
      full = {1'b0, a} + {1'b0, nb} + 9'h001;
      low = {1'b0, a[3:0]} + {1'b0, nb[3:0]} + 5'h01;
      subtract = {(a[7] == nb[7]) && (full[7] != a[7]), full[7:0] == 8'h00, low[4], full[8], full[7:0]};
   endfunction

   logic [7:0] dec_val;
   logic [7:0] inc_val;
   logic [7:0] swapped;
   logic [7:0] bit_mask;
   logic bit_val;
   logic [11:0] sub_mem;
   logic [11:0] sub_imm;

   assign dec_val = i_mem - 8'h01;
   assign inc_val = i_mem + 8'h01;
   assign swapped = {i_mem[3:0], i_mem[7:4]};
   assign bit_mask = 8'h01 << i_bit;
   assign bit_val = |(i_mem & bit_mask);
   assign sub_mem = subtract(i_acc, i_mem);
   assign sub_imm = subtract(i_acc, i_imm);

   always_comb begin
      o_result = i_mem;
      o_wr_mem = 1'b0;
      o_wr_acc = 1'b0;
      o_skip = 1'b0;
      o_flags = i_flags;
      o_table = 1'b0;
      case (i_op)
         skip_exec_pkg::op_dec_to_acc_skip_zero: begin
            o_result = dec_val;
            o_wr_acc = 1'b1;
            o_skip = dec_val == 8'h00;
         end
         skip_exec_pkg::op_set_byte: begin
            o_result = skip_exec_pkg::FILL_BYTE;
            o_wr_mem = 1'b1;
         end
         skip_exec_pkg::op_set_bit: begin
            o_result = i_mem | bit_mask;
            o_wr_mem = 1'b1;
         end
         skip_exec_pkg::op_inc_skip_zero: begin
            o_result = inc_val;
            o_wr_mem = 1'b1;
            o_skip = inc_val == 8'h00;
         end
         skip_exec_pkg::op_inc_to_acc_skip_zero: begin
            o_result = inc_val;
            o_wr_acc = 1'b1;
            o_skip = inc_val == 8'h00;
         end
         skip_exec_pkg::op_skip_bit_nonzero: begin
            o_skip = bit_val;
         end
         skip_exec_pkg::op_subtract_to_acc: begin
            o_result = sub_mem[7:0];
            o_wr_acc = 1'b1;
            o_flags = sub_mem[11:8];
         end
         skip_exec_pkg::op_subtract_to_memory: begin
            o_result = sub_mem[7:0];
            o_wr_mem = 1'b1;
            o_flags = sub_mem[11:8];
         end
         skip_exec_pkg::op_subtract_immediate: begin
            o_result = sub_imm[7:0];
            o_wr_acc = 1'b1;
            o_flags = sub_imm[11:8];
         end
         skip_exec_pkg::op_nibble_exchange: begin
            o_result = swapped;
            o_wr_mem = 1'b1;
         end
         skip_exec_pkg::op_nibble_exchange_to_acc: begin
            o_result = swapped;
            o_wr_acc = 1'b1;
         end
         skip_exec_pkg::op_skip_if_zero: begin
            o_skip = i_mem == 8'h00;
         end
         skip_exec_pkg::op_copy_skip_if_zero: begin
            o_wr_acc = 1'b1;
            o_skip = i_mem == 8'h00;
         end
         skip_exec_pkg::op_skip_bit_zero: begin
            o_skip = !bit_val;
         end
         default: begin
            o_table = 1'b1;
         end
      endcase
   end
endmodule

// >>> design/skip_exec_core.sv
// Summary of operation
// - true skip drops prefetch, adds dummy cycle
// - false skip continues, one cycle only
// - memory minus one to accumulator, skip zero
// - fill addressed byte with all ones
// - set one selected bit of byte
// - increment byte in place, skip zero
// - memory plus one to accumulator, skip zero
// - skip when selected bit is one
// - memory subtract to accumulator or memory, flags
// - immediate subtract to accumulator, update flags
// - swap nibbles of byte in place
// - swapped nibbles into accumulator, memory kept
// - skip when whole byte is zero
// - copy byte to accumulator, skip zero
// - skip when selected bit is zero
// - current page table word to memory, latch
// - last page table word to memory, latch
`timescale 1ns/1ps
module skip_exec_core (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [10:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [3:0] i_byteenable,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   output logic [12:0] o_pmem_addr,
   output logic o_pmem_rd,
   input wire logic [15:0] i_pmem_data
);
   // ----------------------------------------
   // state and storage
   // ----------------------------------------
   typedef enum logic [2:0] {
      st_idle,
      st_dummy,
      st_tbl_addr,
      st_tbl_data,
      st_ack
   } state_t;

   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   state_t state_reg;
   state_t state_next;
   logic wait_reg;
   logic wait_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [7:0] acc_reg;
   logic [7:0] acc_next;
   logic [3:0] flags_reg;
   logic [3:0] flags_next;
   logic skip_reg;
   logic skip_next;
   logic [7:0] table_pointer_reg;
   logic [7:0] table_pointer_next;
   logic [4:0] page_reg;
   logic [4:0] page_next;
   logic [7:0] table_high_byte_latch_reg;
   logic [7:0] table_high_byte_latch_next;
   logic [31:0] instr_reg;
   logic [31:0] instr_next;
   logic [1:0] cycles_reg;
   logic [1:0] cycles_next;
   logic [12:0] paddr_reg;
   logic [12:0] paddr_next;
   logic prd_reg;
   logic prd_next;
   // data memory is local: instructions and the bus share one write port
   logic [7:0] dmem [0:255];

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   logic req;
   logic [31:0] wdata_m;
   logic instr_wr;
   logic reg_wr;
   logic rd_req;
   logic hit_dmem;
   logic [7:0] dmem_idx;
   logic lane0;

   assign req = (i_read | i_write) & wait_reg & (state_reg == st_idle);
   assign wdata_m = i_writedata & lane_mask(i_byteenable);
   assign instr_wr = req & i_write & (i_address == skip_exec_pkg::OFS_INSTR);
   assign reg_wr = req & i_write & !instr_wr;
   assign rd_req = req & i_read & !i_write;
   assign hit_dmem = i_address[skip_exec_pkg::DMEM_SEL_BIT];
   assign dmem_idx = i_address[9:2];
   assign lane0 = i_byteenable[0];

   // ----------------------------------------
   // instruction fields, taken straight from the bus word
   // ----------------------------------------
   skip_exec_pkg::op_t op_in;
   logic [7:0] maddr_in;
   logic [7:0] imm_in;
   logic [2:0] bit_in;
   logic [7:0] mem_in;
   logic is_last_page;

   assign op_in = skip_exec_pkg::op_t'(wdata_m[skip_exec_pkg::OP_LSB +: 4]);
   assign maddr_in = wdata_m[skip_exec_pkg::MADDR_LSB +: 8];
   assign imm_in = wdata_m[skip_exec_pkg::IMM_LSB +: 8];
   assign bit_in = wdata_m[skip_exec_pkg::BIT_LSB +: 3];
   assign mem_in = dmem[maddr_in];
   assign is_last_page = op_in == skip_exec_pkg::op_table_read_last_page;

   // ----------------------------------------
   // execution unit
   // ----------------------------------------
   logic [7:0] alu_result;
   logic alu_wr_mem;
   logic alu_wr_acc;
   logic alu_skip;
   logic [3:0] alu_flags;
   logic alu_table;

   skip_exec_alu u_alu (
      .i_op(op_in),
      .i_acc(acc_reg),
      .i_mem(mem_in),
      .i_imm(imm_in),
      .i_bit(bit_in),
      .i_flags(flags_reg),
      .o_result(alu_result),
      .o_wr_mem(alu_wr_mem),
      .o_wr_acc(alu_wr_acc),
      .o_skip(alu_skip),
      .o_flags(alu_flags),
      .o_table(alu_table)
   );

   logic exec_now;
   logic tbl_start;
   logic tbl_done;

   assign exec_now = instr_wr & !alu_table;
   assign tbl_start = instr_wr & alu_table;
   assign tbl_done = state_reg == st_tbl_data;

   // ----------------------------------------
   // program memory address for table reads
   // ----------------------------------------
   logic [12:0] tbl_addr;

   // last page forces all-ones page bits
   assign tbl_addr = is_last_page ? {skip_exec_pkg::LAST_PAGE, table_pointer_reg} : {page_reg, table_pointer_reg};

   assign paddr_next = tbl_start ? tbl_addr : paddr_reg;
   assign prd_next = tbl_start;

   // ----------------------------------------
   // data memory write port
   // ----------------------------------------
   logic dm_we;
   logic [7:0] dm_addr;
   logic [7:0] dm_wdata;
   logic bus_dm_we;

   assign bus_dm_we = reg_wr & hit_dmem & lane0;
   assign dm_we = (exec_now & alu_wr_mem) | tbl_done | bus_dm_we;
   assign dm_addr = tbl_done ? instr_reg[skip_exec_pkg::MADDR_LSB +: 8] : (bus_dm_we ? dmem_idx : maddr_in);
   // low byte of the program word goes to data memory
   assign dm_wdata = tbl_done ? i_pmem_data[7:0] : (bus_dm_we ? i_writedata[7:0] : alu_result);

   // ----------------------------------------
   // register next values
   // ----------------------------------------
   logic bus_acc_we;
   logic bus_stat_we;

   assign bus_acc_we = reg_wr & lane0 & (i_address == skip_exec_pkg::OFS_ACC);
   assign bus_stat_we = reg_wr & lane0 & (i_address == skip_exec_pkg::OFS_STATUS);

   assign acc_next = (exec_now & alu_wr_acc) ? alu_result : (bus_acc_we ? i_writedata[7:0] : acc_reg);
   // skip and move instructions pass flags through untouched
   assign flags_next = exec_now ? alu_flags : (bus_stat_we ? i_writedata[3:0] : flags_reg);
   assign skip_next = exec_now ? alu_skip : (tbl_start ? 1'b0 : skip_reg);
   assign table_pointer_next = (reg_wr & lane0 & (i_address == skip_exec_pkg::OFS_TABLE_POINTER)) ? i_writedata[7:0] : table_pointer_reg;
   assign page_next = (reg_wr & lane0 & (i_address == skip_exec_pkg::OFS_PC_PAGE)) ? i_writedata[4:0] : page_reg;
   // high byte of the program word lands in the latch
   assign table_high_byte_latch_next = tbl_done ? i_pmem_data[15:8] : table_high_byte_latch_reg;
   assign instr_next = instr_wr ? wdata_m : instr_reg;
   assign cycles_next = tbl_start ? skip_exec_pkg::CYC_TABLE :
                        (exec_now ? (alu_skip ? skip_exec_pkg::CYC_SKIP : skip_exec_pkg::CYC_NOSKIP) : cycles_reg);

   // ----------------------------------------
   // read data select
   // ----------------------------------------
   logic [31:0] rd_sel;
   logic [7:0] stat_byte;

   assign stat_byte = {3'h0, skip_reg, flags_reg};
   assign rd_sel = hit_dmem ? {24'h0, dmem[dmem_idx]} :
                   (i_address == skip_exec_pkg::OFS_INSTR) ? instr_reg :
                   (i_address == skip_exec_pkg::OFS_ACC) ? {24'h0, acc_reg} :
                   (i_address == skip_exec_pkg::OFS_STATUS) ? {24'h0, stat_byte} :
                   (i_address == skip_exec_pkg::OFS_TABLE_POINTER) ? {24'h0, table_pointer_reg} :
                   (i_address == skip_exec_pkg::OFS_PC_PAGE) ? {27'h0, page_reg} :
                   (i_address == skip_exec_pkg::OFS_TABLE_HIGH) ? {24'h0, table_high_byte_latch_reg} :
                   (i_address == skip_exec_pkg::OFS_CYCLES) ? {30'h0, cycles_reg} : 32'h0;
   assign rdata_next = rd_req ? rd_sel : rdata_reg;

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   // waitrequest drops for exactly one cycle, in st_ack's entry edge
   always_comb begin
      state_next = state_reg;
      wait_next = 1'b1;
      case (state_reg)
         st_idle: begin
            if (tbl_start) begin
               state_next = st_tbl_addr;
            end else if (exec_now & alu_skip) begin
               // fetched successor is thrown away; spend a dummy cycle
               state_next = st_dummy;
            end else if (req) begin
               // no skip: answered after the single execute cycle
               state_next = st_ack;
               wait_next = 1'b0;
            end
         end
         st_dummy: begin
            state_next = st_ack;
            wait_next = 1'b0;
         end
         st_tbl_addr: begin
            state_next = st_tbl_data;
         end
         st_tbl_data: begin
            state_next = st_ack;
            wait_next = 1'b0;
         end
         st_ack: begin
            state_next = st_idle;
         end
         default: begin
            state_next = st_idle;
         end
      endcase
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         state_reg <= st_idle;
         wait_reg <= 1'b1;
         rdata_reg <= 32'h0;
         acc_reg <= skip_exec_pkg::ACC_RST;
         flags_reg <= skip_exec_pkg::FLAGS_RST;
         skip_reg <= 1'b0;
         table_pointer_reg <= skip_exec_pkg::TABLE_POINTER_RST;
         page_reg <= skip_exec_pkg::PAGE_RST;
         table_high_byte_latch_reg <= skip_exec_pkg::TABLE_HIGH_BYTE_LATCH_RST;
         instr_reg <= 32'h0;
         cycles_reg <= 2'h0;
         paddr_reg <= 13'h0;
         prd_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         wait_reg <= wait_next;
         rdata_reg <= rdata_next;
         acc_reg <= acc_next;
         flags_reg <= flags_next;
         skip_reg <= skip_next;
         table_pointer_reg <= table_pointer_next;
         page_reg <= page_next;
         table_high_byte_latch_reg <= table_high_byte_latch_next;
         instr_reg <= instr_next;
         cycles_reg <= cycles_next;
         paddr_reg <= paddr_next;
         prd_reg <= prd_next;
      end
   end

   // memory contents are not cleared by reset, as in a plain RAM
   always_ff @(posedge i_clk) begin
      if (dm_we) begin
         dmem[dm_addr] <= dm_wdata;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign o_readdata = rdata_reg;
   assign o_waitrequest = wait_reg;
   assign o_pmem_addr = paddr_reg;
   assign o_pmem_rd = prd_reg;
endmodule

// >>> dv/skip_exec_monitor.sv
`timescale 1ns/1ps
module skip_exec_monitor (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [10:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [3:0] i_byteenable,
   input wire logic [31:0] o_readdata,
   input wire logic o_waitrequest,
   input wire logic [12:0] o_pmem_addr,
   input wire logic o_pmem_rd,
   input wire logic [15:0] i_pmem_data
);
   // ----------------------------------------
   // request tracking
   // ----------------------------------------
   // a held request stays high through dummy cycles, so only the first edge counts
   logic busy_reg;
   logic busy_next;
   wire taken = (i_read | i_write) & o_waitrequest & ~busy_reg;
   wire is_instr = i_write & (i_address == skip_exec_pkg::OFS_INSTR);
   wire instr = taken & is_instr & i_byteenable[0];
   wire [3:0] op = i_writedata[3:0];
   wire tbl = instr & (op[3:1] == 3'h7);
   wire noskip = instr & (op inside {4'h1, 4'h2, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA});
   assign busy_next = taken ? 1'b1 : (o_waitrequest ? busy_reg : 1'b0);
   always_ff @(posedge i_clk) begin
      busy_reg <= i_nrst ? busy_next : 1'b0;
   end

   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   property p_table_timing;
      tbl |=> o_pmem_rd ##1 (!o_pmem_rd && o_waitrequest) ##1 !o_waitrequest;
   endproperty
   a_table_timing: assert property (p_table_timing)
      else $error("table read timing wrong");
   property p_last_page;
      instr && op == 4'hF |=> o_pmem_addr[12:8] == skip_exec_pkg::LAST_PAGE;
   endproperty
   a_last_page: assert property (p_last_page)
      else $error("last page read not on highest page");
   property p_pmem_cause;
      o_pmem_rd |-> $past(tbl);
   endproperty
   a_pmem_cause: assert property (p_pmem_cause)
      else $error("program read without table instruction");
   property p_pmem_hold;
      !tbl |=> $stable(o_pmem_addr);
   endproperty
   a_pmem_hold: assert property (p_pmem_hold)
      else $error("program address moved without table read");
   property p_noskip_one;
      noskip |=> !o_waitrequest;
   endproperty
   a_noskip_one: assert property (p_noskip_one)
      else $error("non-skip instruction not one cycle");
   property p_skip_bound;
      instr && !tbl |=> !o_waitrequest or (o_waitrequest ##1 !o_waitrequest);
   endproperty
   a_skip_bound: assert property (p_skip_bound)
      else $error("instruction took more than two cycles");
   property p_reg_answer;
      taken && !is_instr |=> !o_waitrequest;
   endproperty
   a_reg_answer: assert property (p_reg_answer)
      else $error("register access not answered next cycle");
   property p_wait_pulse;
      !o_waitrequest |=> o_waitrequest;
   endproperty
   a_wait_pulse: assert property (p_wait_pulse)
      else $error("waitrequest low longer than one cycle");
   property p_readdata_hold;
      !(taken && i_read) |=> $stable(o_readdata);
   endproperty
   a_readdata_hold: assert property (p_readdata_hold)
      else $error("readdata changed without a read");
   c_table: cover property (tbl);
   c_skip: cover property (instr && !tbl ##1 o_waitrequest ##1 !o_waitrequest);
   c_read: cover property (taken && i_read);
endmodule

// >>> dv/skip_exec_rom.sv
`timescale 1ns/1ps
// synchronous program memory, one cycle read latency
module skip_exec_rom (
   input wire logic i_clk,
   input wire logic [12:0] i_addr,
   input wire logic i_rd,
   output logic [15:0] o_data
);
   logic [15:0] word_reg = 16'h0F0F;
   assign o_data = word_reg;
   // word encodes its own address; outside a read the lines toggle so stale data is never mistaken
   always @(posedge i_clk) begin
      if (i_rd) begin
         word_reg <= {i_addr[7:0], 3'h0, i_addr[12:8]};
      end else begin
         word_reg <= ~word_reg;
      end
   end
endmodule

// >>> dv/skip_exec_core_tb.sv
`timescale 1ns/1ps
module skip_exec_core_tb;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [10:0] address = 11'h000;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic waitrequest;
   logic [12:0] pmem_addr;
   logic pmem_rd;
   logic [15:0] pmem_data;
   logic [31:0] q;
   int n;
   int fail_count = 0;
   int checks = 0;

   skip_exec_core u_skip_exec_core (.i_clk(clk), .i_nrst(nrst), .i_address(address), .i_read(read),
      .i_write(write), .i_writedata(writedata), .i_byteenable(4'hF), .o_readdata(readdata),
      .o_waitrequest(waitrequest), .o_pmem_addr(pmem_addr), .o_pmem_rd(pmem_rd), .i_pmem_data(pmem_data));
   skip_exec_rom u_skip_exec_rom (.i_clk(clk), .i_addr(pmem_addr), .i_rd(pmem_rd), .o_data(pmem_data));

   initial begin
      forever #2.5 clk = ~clk;
   end

   // ----------------------------------------
   // bus tasks
   // ----------------------------------------
   task automatic final_report;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   // n counts edges from request until waitrequest is seen low
   task automatic xfer(input logic [10:0] a, input logic rw, input logic [31:0] d);
      @(posedge clk);
      address <= a;
      read <= ~rw;
      write <= rw;
      writedata <= d;
      n = 0;
      while (n < 20) begin
         @(posedge clk);
         n++;
         if (waitrequest === 1'b0) break;
      end
      q = readdata;
      if (waitrequest !== 1'b0) begin
         fail_count++;
         final_report();
      end else begin
         read <= 1'b0;
         write <= 1'b0;
      end
   endtask
   task automatic wr(input logic [10:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
      check("write cycles", n, 2);
   endtask
   task automatic rd(input logic [10:0] a, input logic [31:0] exp, input string what);
      xfer(a, 1'b0, 32'h0);
      check(what, q, exp);
   endtask
   function automatic logic [3:0] subf(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] r;
      logic [4:0] l;
      r = {1'b0, a} + {1'b0, ~b} + 9'h001;
      l = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
      return {(a[7] != b[7]) && (r[7] != a[7]), r[7:0] == 8'h00, l[4], r[8]};
   endfunction
   // ecyc: bus edges to answer, 2 plain, 3 skip, 4 table read
   task automatic run(input logic [3:0] op, input logic [2:0] b, input logic [7:0] m, input logic [7:0] imm,
      input logic [7:0] mem0, input logic [7:0] acc0, input logic [7:0] emem, input logic [7:0] eacc,
      input int ecyc, input logic [3:0] ef);
      wr({1'b1, m, 2'h0}, {24'h0, mem0});
      wr(skip_exec_pkg::OFS_ACC, {24'h0, acc0});
      wr(skip_exec_pkg::OFS_STATUS, 32'h0000000A);
      xfer(skip_exec_pkg::OFS_INSTR, 1'b1, {8'h00, imm, m, 1'b0, b, op});
      check("instr cycles", n, ecyc);
      rd(skip_exec_pkg::OFS_CYCLES, (ecyc == 2) ? 32'h1 : 32'h2, "cycles reg");
      rd({1'b1, m, 2'h0}, {24'h0, emem}, "data byte");
      rd(skip_exec_pkg::OFS_ACC, {24'h0, eacc}, "accumulator");
      rd(skip_exec_pkg::OFS_STATUS, {27'h0, ecyc == 3, ef}, "status");
   endtask

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      rd(skip_exec_pkg::OFS_ACC, 32'h0, "acc reset");
      rd(skip_exec_pkg::OFS_STATUS, 32'h0, "status reset");
      rd(skip_exec_pkg::OFS_TABLE_POINTER, 32'h0, "pointer reset");
      rd(skip_exec_pkg::OFS_PC_PAGE, 32'h0, "page reset");
      wr(skip_exec_pkg::OFS_TABLE_HIGH, 32'h77);
      rd(skip_exec_pkg::OFS_TABLE_HIGH, 32'h0, "high latch read only");
      wr(11'h01C, 32'hFF);
      rd(11'h01C, 32'h0, "unmapped");
      run(4'h0, 3'h0, 8'h20, 8'h00, 8'h01, 8'h33, 8'h01, 8'h00, 3, 4'hA);
      run(4'h0, 3'h0, 8'h21, 8'h00, 8'h00, 8'h33, 8'h00, 8'hFF, 2, 4'hA);
      run(4'h1, 3'h0, 8'h22, 8'h00, 8'h12, 8'h33, 8'hFF, 8'h33, 2, 4'hA);
      run(4'h2, 3'h7, 8'h23, 8'h00, 8'h01, 8'h33, 8'h81, 8'h33, 2, 4'hA);
      run(4'h3, 3'h0, 8'h24, 8'h00, 8'hFF, 8'h33, 8'h00, 8'h33, 3, 4'hA);
      run(4'h3, 3'h0, 8'h25, 8'h00, 8'h7F, 8'h33, 8'h80, 8'h33, 2, 4'hA);
      run(4'h4, 3'h0, 8'h26, 8'h00, 8'hFF, 8'h33, 8'hFF, 8'h00, 3, 4'hA);
      run(4'h5, 3'h3, 8'h27, 8'h00, 8'h08, 8'h33, 8'h08, 8'h33, 3, 4'hA);
      run(4'h5, 3'h3, 8'h28, 8'h00, 8'hF7, 8'h33, 8'hF7, 8'h33, 2, 4'hA);
      run(4'h6, 3'h0, 8'h29, 8'h00, 8'h07, 8'h05, 8'h07, 8'hFE, 2, subf(8'h05, 8'h07));
      run(4'h7, 3'h0, 8'h2A, 8'h00, 8'h01, 8'h80, 8'h7F, 8'h80, 2, subf(8'h80, 8'h01));
      run(4'h8, 3'h0, 8'h2B, 8'h10, 8'h55, 8'h10, 8'h55, 8'h00, 2, subf(8'h10, 8'h10));
      run(4'h9, 3'h0, 8'h2C, 8'h00, 8'hA5, 8'h33, 8'h5A, 8'h33, 2, 4'hA);
      run(4'hA, 3'h0, 8'h2D, 8'h00, 8'h3C, 8'h33, 8'h3C, 8'hC3, 2, 4'hA);
      run(4'hB, 3'h0, 8'h2E, 8'h00, 8'h00, 8'h33, 8'h00, 8'h33, 3, 4'hA);
      run(4'hB, 3'h0, 8'h2F, 8'h00, 8'h01, 8'h33, 8'h01, 8'h33, 2, 4'hA);
      run(4'hC, 3'h0, 8'h30, 8'h00, 8'h00, 8'h33, 8'h00, 8'h00, 3, 4'hA);
      run(4'hC, 3'h0, 8'h31, 8'h00, 8'h42, 8'h33, 8'h42, 8'h42, 2, 4'hA);
      run(4'hD, 3'h7, 8'hFF, 8'h00, 8'h80, 8'h33, 8'h80, 8'h33, 2, 4'hA);
      run(4'hD, 3'h0, 8'h32, 8'h00, 8'hFE, 8'h33, 8'hFE, 8'h33, 3, 4'hA);
      wr(skip_exec_pkg::OFS_TABLE_POINTER, 32'h34);
      wr(skip_exec_pkg::OFS_PC_PAGE, 32'h05);
      run(4'hE, 3'h0, 8'h40, 8'h00, 8'h00, 8'h33, 8'h05, 8'h33, 4, 4'hA);
      rd(skip_exec_pkg::OFS_TABLE_HIGH, 32'h34, "high latch current page");
      wr(skip_exec_pkg::OFS_TABLE_POINTER, 32'h56);
      run(4'hF, 3'h0, 8'h41, 8'h00, 8'h00, 8'h33, 8'h1F, 8'h33, 4, 4'hA);
      rd(skip_exec_pkg::OFS_TABLE_HIGH, 32'h56, "high latch last page");
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      rd(skip_exec_pkg::OFS_TABLE_HIGH, 32'h0, "high latch second reset");
      final_report();
   end
endmodule

bind skip_exec_core skip_exec_monitor u_skip_exec_monitor (.i_clk(i_clk), .i_nrst(i_nrst), .i_address(i_address),
   .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
   .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_pmem_addr(o_pmem_addr), .o_pmem_rd(o_pmem_rd),
   .i_pmem_data(i_pmem_data));
